// ---- cpm_monitor.sv ----
`timescale 1ns/1ps
// What this block does
// - Current is shunt times calibration over 4096
// - Power is current times bus code over 5000
// - Power step is twenty current steps
// - Shunt code counts ten microvolts each
// - Bus code stored shifted left three, 4 mV
// - Current and power valid only after calibration
// - Host rewrites settings after every power-up
// - Reset config: 12-bit, /8 gain, 32 V, continuous
// - Host derives calibration from step and shunt
// - Master makes clock, START; address on rising edges
// - Matching address acknowledged on ninth clock
// - Eight bits plus acknowledge; data stable high
// - Master ends with STOP, data rising, clock high
// - 28 ms stall abandons transaction, releases lines
// - Address byte is seven bits plus direction
// - Address is 100 plus high and low codes
// - Select pins sampled at each communication start
// - Device is slave only, never drives clock
// - Clock from 1 kHz to 400 kHz, 2.56 MHz fast
// - Multi-byte values go most significant first
// - Write: pointer byte, then two data bytes
// - Read returns register at last written pointer
// - Master code unacknowledged, high speed until STOP
module cpm_monitor
  import cpm_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = CPM_TIMEOUT_CYC
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  cpm_if.slave             link,
  input  wire logic [15:0] shunt_code,
  input  wire logic [12:0] bus_volt_code,
  input  wire logic        conv_done,
  input  wire logic [1:0]  addr_select_high_pin,
  input  wire logic [1:0]  addr_select_low_pin,
  output logic      [15:0] cfg_word,
  output logic      [15:0] current_result,
  output logic      [15:0] power_result,
  output logic             link_abort
);
  if (TIMEOUT_CYC < 2 || TIMEOUT_CYC >= (1 << CPM_TO_W)) begin : g_chk
    $error("TIMEOUT_CYC out of range");
  end

  // ****************************************
  // Declarations
  // ****************************************
  cpm_link_t                    state_q;
  logic            [3:0]        bc_q, sel1_q, sel2_q;
  logic            [7:0]        sh_q, ptr_q, wmsb_q, wr_ptr_q, tx_byte;
  logic            [6:0]        my_addr_q;
  logic                         bidx_q, hs_q, st_tgl_q, sp_tgl_q, st_seen_q, sp_seen_q;
  logic                         wr_tgl_q, rd_tgl_q, sda_oe_q, pw_upd_q, abort_q;
  logic                         rst_link_n, start_p, stop_p, byte_done, addr_hit, tx_bit;
  logic            [2:0]        wr_s_q, rd_s_q, sc_s_q;
  logic            [15:0]       wr_word_q, cfg_q, cal_q, shunt_q, busv_q, cur_q, pwr_q, rd_snap_q;
  logic            [CPM_TO_W-1:0] to_cnt_q;
  logic signed     [32:0]       cur_prod, cur_div;
  logic signed     [29:0]       pwr_prod, pwr_div;

  // ****************************************
  // Link side, clocked by the serial clock and the data line edges
  // ****************************************
  // A stall abort resets only the transaction; the pointer survives it
  assign rst_link_n = nrst & ~abort_q;
  assign start_p    = st_tgl_q ^ st_seen_q;
  assign stop_p     = sp_tgl_q ^ sp_seen_q;
  assign byte_done  = (bc_q == CPM_ACK_BIT);
  assign addr_hit   = (sh_q[7:1] == my_addr_q);
  assign tx_byte    = bidx_q ? rd_snap_q[7:0] : rd_snap_q[15:8];
  assign tx_bit     = tx_byte[3'(4'd7 - bc_q)];

  // Data edges while the clock is high are framing, not data
  always_ff @(negedge link.sda or negedge nrst) begin
    if (!nrst) st_tgl_q <= 1'b0;
    else if (link.scl) st_tgl_q <= ~st_tgl_q;
  end

  always_ff @(posedge link.sda or negedge nrst) begin
    if (!nrst) sp_tgl_q <= 1'b0;
    else if (link.scl) sp_tgl_q <= ~sp_tgl_q;
  end

  always_ff @(posedge link.scl or negedge nrst) begin
    if (!nrst) begin
      sel1_q <= 4'h0;
      sel2_q <= 4'h0;
    end else begin
      sel1_q <= {addr_select_high_pin, addr_select_low_pin};
      sel2_q <= sel1_q;
    end
  end

  always_ff @(posedge link.scl or negedge rst_link_n) begin
    if (!rst_link_n) begin
      state_q   <= CPM_L_IDLE;
      bc_q      <= 4'h0;
      sh_q      <= 8'h00;
      bidx_q    <= 1'b0;
      hs_q      <= 1'b0;
      my_addr_q <= 7'h00;
    end else if (start_p) begin
      state_q   <= CPM_L_ADDR;
      bc_q      <= 4'h1;
      sh_q      <= {7'h00, link.sda};
      my_addr_q <= {CPM_ADDR_BASE, sel2_q};
      if (stop_p) hs_q <= 1'b0;
    end else if (stop_p) begin
      state_q <= CPM_L_IDLE;
    end else if (state_q != CPM_L_IDLE) begin
      if (!byte_done) begin
        sh_q <= {sh_q[6:0], link.sda};
        bc_q <= bc_q + 4'h1;
        if (state_q == CPM_L_ADDR) my_addr_q <= {CPM_ADDR_BASE, sel2_q};
      end else begin
        bc_q <= 4'h0;
        unique case (state_q)
          CPM_L_ADDR: begin
            if (sh_q[7:3] == CPM_HS_CODE) begin
              hs_q    <= 1'b1;
              state_q <= CPM_L_IDLE;
            end else if (!addr_hit) begin
              state_q <= CPM_L_IDLE;
            end else if (sh_q[0]) begin
              state_q <= CPM_L_RDAT;
              bidx_q  <= 1'b0;
            end else begin
              state_q <= CPM_L_PTR;
            end
          end
          CPM_L_PTR: begin
            state_q <= CPM_L_WDAT;
            bidx_q  <= 1'b0;
          end
          CPM_L_WDAT: bidx_q <= ~bidx_q;
          CPM_L_RDAT: begin
            // A not-acknowledge from the master ends the read
            if (link.sda) state_q <= CPM_L_IDLE;
            else bidx_q <= ~bidx_q;
          end
          CPM_L_IDLE: state_q <= CPM_L_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge link.scl or negedge nrst) begin
    if (!nrst) begin
      st_seen_q <= 1'b0;
      sp_seen_q <= 1'b0;
      ptr_q     <= CPM_REG_CFG;
      wmsb_q    <= 8'h00;
      wr_word_q <= 16'h0000;
      wr_ptr_q  <= CPM_REG_CFG;
      wr_tgl_q  <= 1'b0;
      rd_tgl_q  <= 1'b0;
    end else if (start_p) begin
      st_seen_q <= st_tgl_q;
      sp_seen_q <= sp_tgl_q;
    end else if (byte_done && !stop_p) begin
      if (state_q == CPM_L_PTR) ptr_q <= sh_q;
      if (state_q == CPM_L_WDAT && !bidx_q) wmsb_q <= sh_q;
      if (state_q == CPM_L_WDAT && bidx_q) begin
        wr_word_q <= {wmsb_q, sh_q};
        wr_ptr_q  <= ptr_q;
        wr_tgl_q  <= ~wr_tgl_q;
      end
      if (state_q == CPM_L_ADDR && addr_hit && sh_q[0]) rd_tgl_q <= ~rd_tgl_q;
    end
  end

  // Only the data line is ever driven; the clock belongs to the master
  always_ff @(negedge link.scl or negedge rst_link_n) begin
    if (!rst_link_n) sda_oe_q <= 1'b0;
    else if (byte_done) sda_oe_q <= (state_q == CPM_L_ADDR && addr_hit) ||
                                    state_q == CPM_L_PTR || state_q == CPM_L_WDAT;
    else if (state_q == CPM_L_RDAT) sda_oe_q <= ~tx_bit;
    else sda_oe_q <= 1'b0;
  end

  assign link.s_sda_oe = sda_oe_q;

  // ****************************************
  // Core side, register file and arithmetic
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_s_q <= 3'h0;
      rd_s_q <= 3'h0;
    end else begin
      wr_s_q <= {wr_s_q[1:0], wr_tgl_q};
      rd_s_q <= {rd_s_q[1:0], rd_tgl_q};
    end
  end

  // Settings are volatile and return to defaults only through reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_q <= CPM_CFG_RESET;
      cal_q <= CPM_CAL_RESET;
    end else if (wr_s_q[2] ^ wr_s_q[1]) begin
      if (wr_ptr_q == CPM_REG_CFG) cfg_q <= wr_word_q;
      if (wr_ptr_q == CPM_REG_CAL) cal_q <= wr_word_q;
    end
  end

  // Snapshot is taken long before the first data bit leaves, so it is stable
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rd_snap_q <= 16'h0000;
    else if (rd_s_q[2] ^ rd_s_q[1]) begin
      unique case (ptr_q)
        CPM_REG_CFG:   rd_snap_q <= cfg_q;
        CPM_REG_SHUNT: rd_snap_q <= shunt_q;
        CPM_REG_BUS:   rd_snap_q <= busv_q;
        CPM_REG_PWR:   rd_snap_q <= pwr_q;
        CPM_REG_CUR:   rd_snap_q <= cur_q;
        CPM_REG_CAL:   rd_snap_q <= cal_q;
        default:       rd_snap_q <= 16'h0000;
      endcase
    end
  end

  assign cur_prod = $signed(shunt_code) * $signed({1'b0, cal_q});
  assign cur_div  = cur_prod / CPM_CUR_DIV;
  assign pwr_prod = $signed(cur_q) * $signed({1'b0, busv_q[15:3]});
  assign pwr_div  = pwr_prod / CPM_PWR_DIV;

  // Power follows one cycle after current so it uses the fresh value
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shunt_q  <= 16'h0000;
      busv_q   <= 16'h0000;
      cur_q    <= 16'h0000;
      pwr_q    <= 16'h0000;
      pw_upd_q <= 1'b0;
    end else begin
      pw_upd_q <= conv_done;
      if (conv_done) begin
        shunt_q <= shunt_code;
        busv_q  <= {bus_volt_code, CPM_BUS_PAD};
        cur_q   <= cur_div[15:0];
      end
      if (pw_upd_q) pwr_q <= pwr_div[15:0];
    end
  end

  // Only a clock held low counts; a frozen high clock is an idle bus
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sc_s_q   <= 3'h7;
      to_cnt_q <= '0;
      abort_q  <= 1'b0;
    end else begin
      sc_s_q <= {sc_s_q[1:0], link.scl};
      if (sc_s_q[1] || sc_s_q[2]) begin
        to_cnt_q <= '0;
        abort_q  <= 1'b0;
      end else if (to_cnt_q == CPM_TO_W'(TIMEOUT_CYC - 1)) begin
        abort_q <= 1'b1;
      end else begin
        to_cnt_q <= to_cnt_q + 1'b1;
      end
    end
  end
  assign cfg_word       = cfg_q;
  assign current_result = cur_q;
  assign power_result   = pwr_q;
  assign link_abort     = abort_q;
endmodule

// ---- cpm_pkg.sv ----
package cpm_pkg;

  // ****************************************
  // Register pointer values
  // ****************************************
  localparam logic [7:0] CPM_REG_CFG   = 8'h00;
  localparam logic [7:0] CPM_REG_SHUNT = 8'h01;
  localparam logic [7:0] CPM_REG_BUS   = 8'h02;
  localparam logic [7:0] CPM_REG_PWR   = 8'h03;
  localparam logic [7:0] CPM_REG_CUR   = 8'h04;
  localparam logic [7:0] CPM_REG_CAL   = 8'h05;

  // ****************************************
  // Field values and reset values
  // ****************************************
  localparam logic       CPM_BRNG_32V  = 1'h1;
  localparam logic [1:0] CPM_GAIN_DIV8 = 2'h3;
  localparam logic [3:0] CPM_BADC_12B  = 4'h3;
  localparam logic [3:0] CPM_SADC_12B  = 4'h3;
  localparam logic [2:0] CPM_MODE_CONT = 3'h7;
  localparam logic [15:0] CPM_CFG_RESET = {2'h0, CPM_BRNG_32V, CPM_GAIN_DIV8,
                                           CPM_BADC_12B, CPM_SADC_12B, CPM_MODE_CONT};
  localparam logic [15:0] CPM_CAL_RESET = 16'h0000;
  localparam logic [2:0]  CPM_BUS_PAD   = 3'h0;
  localparam int          CPM_SHUNT_LSB_UV = 10;
  localparam int          CPM_BUS_LSB_MV   = 4;
  localparam int          CPM_PWR_LSB_MULT = 20;
  localparam logic signed [32:0] CPM_CUR_DIV = 33'sh1000;
  localparam logic signed [29:0] CPM_PWR_DIV = 30'sh1388;

  // ****************************************
  // Serial bus constants
  // ****************************************
  localparam logic [2:0] CPM_ADDR_BASE = 3'h4;
  localparam logic [4:0] CPM_HS_CODE   = 5'h01;
  localparam logic [3:0] CPM_ACK_BIT   = 4'h8;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CPM_CLK_KHZ     = 250000;
  localparam int CPM_TIMEOUT_MS  = 28;
  localparam int CPM_TIMEOUT_CYC = CPM_TIMEOUT_MS * CPM_CLK_KHZ;
  localparam int CPM_TO_W        = 23;
  localparam int CPM_SCL_KHZ     = 400;
  localparam int CPM_SCL_MIN_KHZ = 1;
  localparam int CPM_QTR_CYC     = (CPM_CLK_KHZ + 4 * CPM_SCL_KHZ - 1) / (4 * CPM_SCL_KHZ);
  localparam int CPM_QTR_MAX     = CPM_CLK_KHZ / (4 * CPM_SCL_MIN_KHZ);

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [4:0] {
    CPM_L_IDLE = 5'h01,
    CPM_L_ADDR = 5'h02,
    CPM_L_PTR  = 5'h04,
    CPM_L_WDAT = 5'h08,
    CPM_L_RDAT = 5'h10
  } cpm_link_t;

  typedef enum logic [3:0] {
    CPM_H_IDLE  = 4'h1,
    CPM_H_START = 4'h2,
    CPM_H_BIT   = 4'h4,
    CPM_H_STOP  = 4'h8
  } cpm_host_t;

  typedef enum logic [1:0] {
    CPM_CMD_WRITE = 2'h0,
    CPM_CMD_PTR   = 2'h1,
    CPM_CMD_READ  = 2'h2
  } cpm_cmd_t;

endpackage

// ---- cpm_if.sv ----
`timescale 1ns/1ps
interface cpm_if;
  logic m_scl_oe;
  logic m_sda_oe;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // Open-drain wires with pull-ups: any enable pulls the line low
  assign scl = ~m_scl_oe;
  assign sda = ~(m_sda_oe | s_sda_oe);

  modport master (output m_scl_oe, output m_sda_oe, input sda);
  modport slave  (output s_sda_oe, input scl, input sda);
endinterface

// ---- cpm_master.sv ----
`timescale 1ns/1ps
module cpm_master
  import cpm_pkg::*;
#(
  parameter int unsigned QTR_CYC = CPM_QTR_CYC
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  cpm_if.master            link,
  input  wire logic        cmd_valid,
  input  wire cpm_cmd_t    cmd_kind,
  input  wire logic [6:0]  cmd_addr,
  input  wire logic [7:0]  cmd_ptr,
  input  wire logic [15:0] cmd_wdata,
  output logic             cmd_ready,
  output logic             rsp_valid,
  output logic      [15:0] rsp_data,
  output logic             rsp_nack
);

  // Clock kept between 1 kHz and 400 kHz
  if (QTR_CYC < CPM_QTR_CYC || QTR_CYC > CPM_QTR_MAX) begin : g_chk
    $error("QTR_CYC out of range");
  end

  // ****************************************
  // Declarations
  // ****************************************
  cpm_host_t          st_q;
  cpm_cmd_t           kind_q;
  logic      [15:0]   div_q;
  logic      [1:0]    qc_q;
  logic      [1:0]    bi_q;
  logic      [1:0]    last_q;
  logic      [3:0]    bt_q;
  logic      [6:0]    addr_q;
  logic      [7:0]    ptr_q;
  logic      [15:0]   wdata_q;
  logic      [15:0]   rdata_q;
  logic               nack_q;
  logic               ready_q;
  logic               rsp_q;
  logic               scl_oe_q;
  logic               sda_oe_q;
  logic      [1:0]    sda_s_q;
  logic               tick;
  logic               rx;
  logic      [7:0]    tx_byte;

  assign tick = (div_q == 16'h0000);
  assign rx   = (kind_q == CPM_CMD_READ) && (bi_q != 2'h0);

  always_comb begin
    unique case (bi_q)
      2'h0: tx_byte = {addr_q, kind_q == CPM_CMD_READ};
      2'h1: tx_byte = ptr_q;
      2'h2: tx_byte = wdata_q[15:8];
      2'h3: tx_byte = wdata_q[7:0];
    endcase
  end

  // ****************************************
  // Divider and data line synchroniser
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_q   <= 16'h0000;
      sda_s_q <= 2'h3;
    end else begin
      sda_s_q <= {sda_s_q[0], link.sda};
      if (st_q == CPM_H_IDLE || tick) div_q <= 16'(QTR_CYC - 1);
      else div_q <= div_q - 16'h0001;
    end
  end

  // ****************************************
  // Transfer sequencer, four phases per bit
  // ****************************************
  // No clock stretching: a slave that holds the clock low is not waited for
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q     <= CPM_H_IDLE;
      kind_q   <= CPM_CMD_WRITE;
      qc_q     <= 2'h0;
      bi_q     <= 2'h0;
      last_q   <= 2'h0;
      bt_q     <= 4'h0;
      addr_q   <= 7'h00;
      ptr_q    <= 8'h00;
      wdata_q  <= 16'h0000;
      rdata_q  <= 16'h0000;
      nack_q   <= 1'b0;
      ready_q  <= 1'b1;
      rsp_q    <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      rsp_q <= 1'b0;
      unique case (st_q)
        CPM_H_IDLE: if (cmd_valid) begin
          st_q    <= CPM_H_START;
          kind_q  <= cmd_kind;
          addr_q  <= cmd_addr;
          ptr_q   <= cmd_ptr;
          wdata_q <= cmd_wdata;
          last_q  <= (cmd_kind == CPM_CMD_WRITE) ? 2'h3 : (cmd_kind == CPM_CMD_READ) ? 2'h2 : 2'h1;
          qc_q    <= 2'h0;
          bi_q    <= 2'h0;
          bt_q    <= 4'h0;
          nack_q  <= 1'b0;
          ready_q <= 1'b0;
        end
        CPM_H_START: if (tick) begin
          qc_q <= qc_q + 2'h1;
          if (qc_q == 2'h0) sda_oe_q <= 1'b1;
          if (qc_q == 2'h2) scl_oe_q <= 1'b1;
          if (qc_q == 2'h3) st_q <= CPM_H_BIT;
        end
        CPM_H_BIT: if (tick) begin
          qc_q <= qc_q + 2'h1;
          unique case (qc_q)
            2'h0: sda_oe_q <= (bt_q == CPM_ACK_BIT) ? (rx && bi_q != last_q) :
                              (!rx && !tx_byte[3'(4'd7 - bt_q)]);
            2'h1: scl_oe_q <= 1'b0;
            2'h2: begin
              if (bt_q != CPM_ACK_BIT && rx) rdata_q <= {rdata_q[14:0], sda_s_q[1]};
              else if (bt_q == CPM_ACK_BIT && !rx && sda_s_q[1]) nack_q <= 1'b1;
            end
            2'h3: begin
              scl_oe_q <= 1'b1;
              if (bt_q != CPM_ACK_BIT) bt_q <= bt_q + 4'h1;
              else begin
                bt_q <= 4'h0;
                if (nack_q || bi_q == last_q) st_q <= CPM_H_STOP;
                else bi_q <= bi_q + 2'h1;
              end
            end
          endcase
        end
        CPM_H_STOP: if (tick) begin
          qc_q <= qc_q + 2'h1;
          if (qc_q == 2'h0) sda_oe_q <= 1'b1;
          if (qc_q == 2'h1) scl_oe_q <= 1'b0;
          if (qc_q == 2'h2) sda_oe_q <= 1'b0;
          if (qc_q == 2'h3) begin
            st_q    <= CPM_H_IDLE;
            rsp_q   <= 1'b1;
            ready_q <= 1'b1;
          end
        end
      endcase
    end
  end

  assign link.m_scl_oe = scl_oe_q;
  assign link.m_sda_oe = sda_oe_q;
  assign cmd_ready     = ready_q;
  assign rsp_valid     = rsp_q;
  assign rsp_data      = rdata_q;
  assign rsp_nack      = nack_q;

endmodule

// ---- cpm_assertions.sv ----
`timescale 1ns/1ps
module cpm_assertions (
  input wire logic clk,
  input wire logic nrst,
  input wire logic m_scl_oe,
  input wire logic m_sda_oe,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  // ****************************************
  // Bus event tracking in the core clock
  // ****************************************
  logic       scl_q;
  logic       sda_q;
  logic       rd_q;
  logic [7:0] rise_cnt_q;
  wire        start = scl && scl_q && sda_q && !sda;
  wire        stop  = scl && scl_q && !sda_q && sda;
  wire        rise  = scl && !scl_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // Rises since the last START; the ninth rise of each byte is the ack clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rise_cnt_q <= 8'h00;
    end else if (start) begin
      rise_cnt_q <= 8'h00;
    end else if (rise) begin
      rise_cnt_q <= rise_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_q <= 1'h0;
    end else if (rise && rise_cnt_q == 8'h07) begin
      rd_q <= sda;
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence start_seq;
    start;
  endsequence

  sequence idle_hold;
    (scl && sda) [*4];
  endsequence

  a_dev_data_hold: assert property ($changed(s_sda_oe) |-> !scl)
    else $error("device data changed while clock high");
  a_no_addr_drive: assert property ((rise_cnt_q < 8'h08) |-> !s_sda_oe)
    else $error("device drove data during address bits");
  a_ack_ninth: assert property (($rose(s_sda_oe) && rise_cnt_q == 8'h08)
    |-> ##[1:700] (rise_cnt_q == 8'h09 && scl && !sda))
    else $error("address ack missing on ninth clock");
  a_start_clk_hold: assert property (start_seq |-> scl [*8])
    else $error("clock not held high after start");
  a_mstr_data_hold: assert property (($changed(m_sda_oe) && scl)
    |-> (rise_cnt_q % 9 == 1 || rise_cnt_q == 8'h00))
    else $error("master data changed while clock high");
  a_stop_idle: assert property (stop |-> idle_hold)
    else $error("bus not idle after stop");
  a_ack_release: assert property (($fell(scl) && rise_cnt_q == 8'h09 && !rd_q) |=> !s_sda_oe)
    else $error("ack held past ninth clock");
  a_read_release: assert property (($fell(scl) && rd_q && rise_cnt_q == 8'h1b) |=> !s_sda_oe)
    else $error("data held after last read byte");
endmodule

// ---- test_current_power_calc_i2c_slave.sv ----
`timescale 1ns/1ps
module test_current_power_calc_i2c_slave
  import cpm_pkg::*;
;
  logic        clk, nrst, cmd_valid, cmd_ready, rsp_valid, rsp_nack, conv_done, link_abort, abort2;
  cpm_cmd_t    cmd_kind;
  logic [6:0]  cmd_addr;
  logic [7:0]  cmd_ptr;
  logic [15:0] cmd_wdata, rsp_data, shunt_code, cfg_word, current_result, power_result;
  logic [12:0] bus_volt_code;
  logic [1:0]  addr_select_high_pin, addr_select_low_pin;
  int          n_mismatch = 0, total_checks = 0, cyc = 0, ec, ep;
  cpm_if       link();
  cpm_if       link2();

  cpm_master cpm_master_i (.clk, .nrst, .link(link.master), .cmd_valid, .cmd_kind, .cmd_addr, .cmd_ptr,
    .cmd_wdata, .cmd_ready, .rsp_valid, .rsp_data, .rsp_nack);
  cpm_monitor #(.TIMEOUT_CYC(2000)) cpm_monitor_i (.clk, .nrst, .link(link.slave), .shunt_code,
    .bus_volt_code, .conv_done, .addr_select_high_pin, .addr_select_low_pin, .cfg_word,
    .current_result, .power_result, .link_abort);
  // Short timeout so the stall case fits the run; its link is driven by hand
  cpm_monitor #(.TIMEOUT_CYC(200)) cpm_monitor_i2 (.clk, .nrst, .link(link2.slave), .shunt_code,
    .bus_volt_code, .conv_done, .addr_select_high_pin, .addr_select_low_pin, .cfg_word(),
    .current_result(), .power_result(), .link_abort(abort2));
  cpm_assertions cpm_assertions_i (.clk, .nrst, .m_scl_oe(link.m_scl_oe), .m_sda_oe(link.m_sda_oe),
    .s_sda_oe(link.s_sda_oe), .scl(link.scl), .sda(link.sda));

  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 99000) begin
      n_mismatch++;
      wrap_up;
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task wrap_up;
    $display("mismatches %0d checks %0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task cmd(input cpm_cmd_t k, input logic [6:0] a, input logic [7:0] p, input logic [15:0] w);
    int i;
    @(negedge clk);
    cmd_kind = k;
    cmd_addr = a;
    cmd_ptr = p;
    cmd_wdata = w;
    cmd_valid = 1'h1;
    @(negedge clk);
    cmd_valid = 1'h0;
    for (i = 0; i < 30000 && rsp_valid !== 1'h1; i++) @(negedge clk);
    if (i == 30000) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, 1'h0, 1'h1);
    end
  endtask

  task conv;
    @(negedge clk) conv_done = 1'h1;
    @(negedge clk) conv_done = 1'h0;
    repeat (4) @(negedge clk);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task t_uncal;
    conv;
    chk(current_result, 16'h0000);
    chk(power_result, 16'h0000);
    chk(cfg_word, CPM_CFG_RESET);
  endtask

  task t_reset_read;
    cmd(CPM_CMD_READ, 7'h49, 8'h00, 16'h0000);
    chk(rsp_data, CPM_CFG_RESET);
    chk(16'(rsp_nack), 16'h0000);
    chk(16'(cmd_ready), 16'h0001);
  endtask

  // Link clock of 12 ns made here; stall with the ack driven must drop it
  task t_timeout;
    logic [7:0] b;
    b = {7'h49, 1'h0};
    repeat (3) begin
      #6 link2.m_scl_oe = 1'h1;
      #6 link2.m_scl_oe = 1'h0;
    end
    #3 link2.m_sda_oe = 1'h1;
    #6 link2.m_scl_oe = 1'h1;
    for (int i = 7; i >= 0; i--) begin
      #3 link2.m_sda_oe = ~b[i];
      #3 link2.m_scl_oe = 1'h0;
      #6 link2.m_scl_oe = 1'h1;
    end
    #3 link2.m_sda_oe = 1'h0;
    repeat (50) @(negedge clk);
    chk(16'(link2.s_sda_oe), 16'h0001);
    chk(16'(abort2), 16'h0000);
    repeat (200) @(negedge clk);
    chk(16'(abort2), 16'h0001);
    chk(16'(link2.s_sda_oe), 16'h0000);
    link2.m_scl_oe = 1'h0;
    repeat (10) @(negedge clk);
    chk(16'(abort2), 16'h0000);
  endtask

  task t_calc;
    cmd(CPM_CMD_WRITE, 7'h49, CPM_REG_CAL, 16'h0800);
    chk(16'(rsp_nack), 16'h0000);
    chk(16'(link_abort), 16'h0000);
    conv;
    ec = (int'($signed(shunt_code)) * 2048) / 4096;
    ep = (ec * int'(bus_volt_code)) / 5000;
    chk(current_result, ec[15:0]);
    chk(power_result, ep[15:0]);
  endtask

  // A pin change is honoured from the very next transaction; nacked ones keep the pointer
  task t_pins_and_read;
    addr_select_low_pin = 2'h0;
    cmd(CPM_CMD_PTR, 7'h48, CPM_REG_CUR, 16'h0000);
    chk(16'(rsp_nack), 16'h0000);
    cmd(CPM_CMD_PTR, 7'h49, CPM_REG_CUR, 16'h0000);
    chk(16'(rsp_nack), 16'h0001);
    cmd(CPM_CMD_PTR, 7'h04, CPM_REG_CFG, 16'h0000);
    chk(16'(rsp_nack), 16'h0001);
    cmd(CPM_CMD_READ, 7'h48, 8'h00, 16'h0000);
    chk(rsp_data, ec[15:0]);
  endtask

  initial begin
    nrst = 1'h0;
    cmd_valid = 1'h0;
    cmd_kind = CPM_CMD_READ;
    cmd_addr = 7'h49;
    cmd_ptr = 8'h00;
    cmd_wdata = 16'h0000;
    conv_done = 1'h0;
    shunt_code = 16'hfed3;
    bus_volt_code = 13'h1387;
    addr_select_high_pin = 2'h2;
    addr_select_low_pin = 2'h1;
    link2.m_scl_oe = 1'h0;
    link2.m_sda_oe = 1'h0;
    repeat (8) @(posedge clk);
    @(negedge clk) nrst = 1'h1;
    t_uncal;
    t_reset_read;
    t_timeout;
    t_calc;
    t_pins_and_read;
    wrap_up;
  end
endmodule
